// >>> design/hswb_pkg.sv
// Package: constants and carrier types of the host sliding window bridge
package hswb_pkg;

  // ---------------------------------------------------------------
  // Address widths and memory map
  // ---------------------------------------------------------------
  localparam int HOST_AW    = 24;        // ISA memory address bits
  localparam int LOCAL_AW   = 26;        // 64 MByte on-board space
  localparam int IO_AW      = 10;        // Host I/O decode, 0 - 1K
  localparam int WIN_LSB    = 8;         // Base / mask start at bit 8
  localparam int TGT_LSB    = 10;        // Target offset starts at bit 10
  localparam logic [LOCAL_AW-1:0] FLASH_BASE = 26'h3f80000; // Top 512 KB
  localparam logic [LOCAL_AW-1:0] DRAM_LIMIT = 26'h0800000; // 8 MB fitted

  // ---------------------------------------------------------------
  // Direct register offsets from the switch base
  // ---------------------------------------------------------------
  localparam logic [3:0] OFS_HOST_BASE   = 4'h0;
  localparam logic [3:0] OFS_SIZE_MASK   = 4'h2;
  localparam logic [3:0] OFS_TGT_OFFSET  = 4'h4;
  localparam logic [3:0] OFS_IO_BASE     = 4'h6;
  localparam logic [3:0] OFS_IO_SIZE     = 4'h7;
  localparam logic [3:0] OFS_IO_TGT      = 4'h8;
  localparam logic [3:0] OFS_BOARD_CTRL  = 4'hf;

  // Reset values: I/O window off; memory window open on host 000000-0000FF until programmed
  localparam logic [15:0] RST_HOST_BASE  = 16'h0000;
  localparam logic [15:0] RST_SIZE_MASK  = 16'hffff;
  localparam logic [15:0] RST_TGT_OFFSET = 16'h0000;
  localparam logic [7:0]  RST_IO_BASE    = 8'h00;
  localparam logic [7:0]  RST_IO_SIZE    = 8'hff;
  localparam logic [7:0]  RST_BOARD_CTRL = 8'h01; // Local CPU halted
  localparam int          BC_HALT_BIT    = 0;
  localparam int          BC_IOWIN_EN    = 1;

  // Local processor clock divider: 100 MHz down to 16 MHz class
  localparam int REF_CLK_MHZ  = 100;
  localparam int LPROC_MHZ    = 16;
  localparam int LPROC_DIV    = REF_CLK_MHZ / (2 * LPROC_MHZ);

  // Local memory masters
  typedef enum logic [1:0] {
    HSWB_M_NONE,
    HSWB_M_HOST,
    HSWB_M_LPROC,
    HSWB_M_HDLC
  } hswb_master_t;

  // Local memory request carrier
  typedef struct packed {
    logic                valid;
    logic                write;
    logic [LOCAL_AW-1:0] addr;
    logic [15:0]         wdata;
    logic [1:0]          be;      // [0] even byte, [1] odd byte
  } hswb_mreq_t;

  // Local I/O request carrier
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [9:0]  addr;
    logic [7:0]  wdata;
  } hswb_ioreq_t;

endpackage : hswb_pkg

// >>> design/hswb_bridge.sv
// Module: host sliding window bridge, local bus arbitration and decode
//
// Operation
// - Target equals host minus base plus offset
// - Mapping changes take effect immediately
// - Offset gives first window byte's address
// - On-board space spans 64 MBytes
// - DRAM low, flash high addresses
// - 16-bit path, even/odd byte lanes
// - Flash 512 KB in 11 sectors
// - Flash reads any address, writes whole sector
// - Memory bus serves host, processor, HDLC
// - I/O bus served by host or processor
// - Memory and I/O buses run independently
// - Autonomous or host control, processor halted
// - Answer host memory and I/O, raise IRQ
// - Direct registers plus movable I/O window
// - Sixteen registers at switch base, 16-aligned
// - Local processor clocked at about 16.7 MHz
// - Base holds host bits 23:8
// - Size mask over bits above low eight
// - Offset supplies local bits 25:10
// - Switches map bits 4..9, on reads zero
//
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/1ps

module hswb_bridge (
  input  wire logic                     ref_clk,
  input  wire logic                     srst,
  // Board switches: [5:0] I/O base, [7:6] board number; on reads zero
  input  wire logic [7:0]               config_switch_bank,
  // Host memory cycle
  input  wire logic                     host_mem_req,
  input  wire logic                     host_mem_write,
  input  wire logic [23:0]              host_mem_addr,
  input  wire logic [15:0]              host_mem_wdata,
  input  wire logic [1:0]               host_mem_be,
  output logic                          host_mem_claim,
  output logic                          host_mem_ack,
  output logic [15:0]                   host_mem_rdata,
  // Host I/O cycle (register bus)
  input  wire logic [9:0]               host_io_addr,
  input  wire logic [7:0]               host_io_wdata,
  input  wire logic                     host_io_wr,
  input  wire logic                     host_io_rd,
  output logic [7:0]                    host_io_rdata,
  output logic                          host_io_claim,
  // Interrupt request from local devices
  input  wire logic                     dev_irq,
  output logic                          host_irq,
  // Local processor side
  input  wire hswb_pkg::hswb_mreq_t     lproc_mreq,
  input  wire hswb_pkg::hswb_ioreq_t    lproc_ioreq,
  output logic                          lproc_mgnt,
  output logic                          lproc_iognt,
  output logic                          lproc_halt,
  output logic                          lproc_clk,
  // HDLC controller memory master
  input  wire hswb_pkg::hswb_mreq_t     hdlc_mreq,
  output logic                          hdlc_mgnt,
  // Local memory bus
  output hswb_pkg::hswb_mreq_t          mem_bus,
  output logic                          mem_dram_sel,
  output logic                          mem_flash_sel,
  output logic [3:0]                    mem_flash_sector,
  output logic [1:0]                    mem_lane_en,
  input  wire logic [15:0]              mem_rdata,
  // Local I/O bus
  output hswb_pkg::hswb_ioreq_t         io_bus,
  input  wire logic [7:0]               io_rdata
);

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  // Flash sector index from offset inside the 512 KB flash
  function automatic logic [3:0] flash_sector(input logic [18:0] ofs);
    logic [3:0] s;
    s = 4'h0;
    if (ofs[18:16] != 3'h7)
      s = {1'b0, ofs[18:16]};                   // Seven 64 KB sectors
    else if (ofs[15] == 1'b0)
      s = 4'h7;                                 // 32 KB sector
    else if (ofs[14] == 1'b0)
      s = 4'h8;                                 // 16 KB sector
    else
      s = ofs[13] ? 4'ha : 4'h9;                // Two 8 KB sectors
    return s;
  endfunction : flash_sector

  // ---------------------------------------------------------------
  // Direct register state
  // ---------------------------------------------------------------
  logic [15:0] host_window_base_r;
  logic [15:0] window_size_mask_r;
  logic [15:0] target_window_offset_r;
  logic [7:0]  io_win_base_r;
  logic [7:0]  io_win_size_r;
  logic [7:0]  io_win_tgt_r;
  logic [7:0]  board_ctrl_r;
  logic [7:0]  io_rdata_nxt;
  logic        io_dir_hit;
  logic [3:0]  io_ofs;
  logic [5:0]  sw_base;

  // Switch on reads zero, so the bank itself is the address value
  assign sw_base    = config_switch_bank[5:0];
  assign io_ofs     = host_io_addr[3:0];
  assign io_dir_hit = host_io_addr[9:4] == sw_base;

  // Register writes; each rewrite of the window acts at once
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      host_window_base_r     <= hswb_pkg::RST_HOST_BASE;
      window_size_mask_r     <= hswb_pkg::RST_SIZE_MASK;
      target_window_offset_r <= hswb_pkg::RST_TGT_OFFSET;
      io_win_base_r          <= hswb_pkg::RST_IO_BASE;
      io_win_size_r          <= hswb_pkg::RST_IO_SIZE;
      io_win_tgt_r           <= hswb_pkg::RST_IO_BASE;
      board_ctrl_r           <= hswb_pkg::RST_BOARD_CTRL;
    end
    else if (host_io_wr && io_dir_hit)
    begin
      // 16-bit registers take low byte at even, high byte at odd
      case (io_ofs)
        hswb_pkg::OFS_HOST_BASE:     host_window_base_r[7:0] <= host_io_wdata;
        hswb_pkg::OFS_HOST_BASE+4'h1:
          host_window_base_r[15:8] <= host_io_wdata;
        hswb_pkg::OFS_SIZE_MASK:     window_size_mask_r[7:0] <= host_io_wdata;
        hswb_pkg::OFS_SIZE_MASK+4'h1:
          window_size_mask_r[15:8] <= host_io_wdata;
        hswb_pkg::OFS_TGT_OFFSET:
          target_window_offset_r[7:0] <= host_io_wdata;
        hswb_pkg::OFS_TGT_OFFSET+4'h1:
          target_window_offset_r[15:8] <= host_io_wdata;
        hswb_pkg::OFS_IO_BASE:       io_win_base_r  <= host_io_wdata;
        hswb_pkg::OFS_IO_SIZE:       io_win_size_r  <= host_io_wdata;
        hswb_pkg::OFS_IO_TGT:        io_win_tgt_r   <= host_io_wdata;
        hswb_pkg::OFS_BOARD_CTRL:    board_ctrl_r   <= host_io_wdata;
        default:                     board_ctrl_r   <= board_ctrl_r;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Memory window decode
  // ---------------------------------------------------------------
  logic                          win_hit;
  logic [23:0]                   win_rel;
  logic [hswb_pkg::LOCAL_AW-1:0] host_tgt;

  // Masked compare of bits 23:8 against the base
  assign win_hit = ((host_mem_addr[23:8] ^ host_window_base_r)
                    & window_size_mask_r) == 16'h0000;
  // Offset into window; all base bits, under the mask or not, are subtracted
  assign win_rel  = host_mem_addr - {host_window_base_r, 8'h00};
  assign host_tgt = hswb_pkg::LOCAL_AW'({2'b00, win_rel}
                    + {target_window_offset_r, 10'h000});
  assign host_mem_claim = host_mem_req && win_hit;

  // ---------------------------------------------------------------
  // Local memory arbitration: host, then HDLC, then processor
  // ---------------------------------------------------------------
  hswb_pkg::hswb_master_t        mgnt_nxt;
  hswb_pkg::hswb_master_t        mgnt_r;
  hswb_pkg::hswb_mreq_t          mreq_nxt;

  // Host first so PC cycles never starve; HDLC beats processor
  always_comb
  begin
    mgnt_nxt = hswb_pkg::HSWB_M_NONE;
    mreq_nxt = '0;
    if (host_mem_claim)
    begin
      mgnt_nxt       = hswb_pkg::HSWB_M_HOST;
      mreq_nxt.valid = 1'b1;
      mreq_nxt.write = host_mem_write;
      mreq_nxt.addr  = host_tgt;
      mreq_nxt.wdata = host_mem_wdata;
      mreq_nxt.be    = host_mem_be;
    end
    else if (hdlc_mreq.valid)
    begin
      mgnt_nxt = hswb_pkg::HSWB_M_HDLC;
      mreq_nxt = hdlc_mreq;
    end
    else if (lproc_mreq.valid && !board_ctrl_r[hswb_pkg::BC_HALT_BIT])
    begin
      mgnt_nxt = hswb_pkg::HSWB_M_LPROC;
      mreq_nxt = lproc_mreq;
    end
  end

  // Registered local memory cycle
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      mgnt_r           <= hswb_pkg::HSWB_M_NONE;
      mem_bus          <= '0;
      mem_dram_sel     <= 1'b0;
      mem_flash_sel    <= 1'b0;
      mem_flash_sector <= 4'h0;
      mem_lane_en      <= 2'b00;
    end
    else
    begin
      mgnt_r        <= mgnt_nxt;
      mem_bus       <= mreq_nxt;
      mem_lane_en   <= mreq_nxt.valid ? mreq_nxt.be : 2'b00;
      mem_dram_sel  <= mreq_nxt.valid
                       && mreq_nxt.addr < hswb_pkg::DRAM_LIMIT;
      mem_flash_sel <= mreq_nxt.valid
                       && mreq_nxt.addr >= hswb_pkg::FLASH_BASE;
      mem_flash_sector <= flash_sector(mreq_nxt.addr[18:0]);
    end
  end

  assign lproc_mgnt = mgnt_r == hswb_pkg::HSWB_M_LPROC;
  assign hdlc_mgnt  = mgnt_r == hswb_pkg::HSWB_M_HDLC;

  // Host memory answer, one cycle after the claim
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      host_mem_ack   <= 1'b0;
      host_mem_rdata <= 16'h0000;
    end
    else
    begin
      host_mem_ack   <= mgnt_nxt == hswb_pkg::HSWB_M_HOST;
      host_mem_rdata <= mem_rdata;
    end
  end

  // ---------------------------------------------------------------
  // Local I/O bus: independent of the memory bus
  // ---------------------------------------------------------------
  logic       io_win_hit;
  logic [7:0] io_win_rel;
  logic       io_host_cyc;

  // Movable window in 4-byte steps; low two bits pass through
  assign io_win_hit  = board_ctrl_r[hswb_pkg::BC_IOWIN_EN] && !io_dir_hit
                       && (((host_io_addr[9:2] ^ io_win_base_r)
                       & io_win_size_r) == 8'h00);
  assign io_win_rel  = host_io_addr[9:2] - io_win_base_r;
  assign io_host_cyc = io_win_hit && (host_io_wr || host_io_rd);
  assign host_io_claim = io_dir_hit || io_win_hit;

  // Host has the I/O bus when active; processor otherwise, unless halted
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      io_bus      <= '0;
      lproc_iognt <= 1'b0;
    end
    else if (io_host_cyc)
    begin
      io_bus.valid <= 1'b1;
      io_bus.write <= host_io_wr;
      io_bus.addr  <= {io_win_rel + io_win_tgt_r, host_io_addr[1:0]};
      io_bus.wdata <= host_io_wdata;
      lproc_iognt  <= 1'b0;
    end
    else
    begin
      io_bus      <= lproc_ioreq;
      lproc_iognt <= lproc_ioreq.valid
                     && !board_ctrl_r[hswb_pkg::BC_HALT_BIT];
      if (board_ctrl_r[hswb_pkg::BC_HALT_BIT])
        io_bus.valid <= 1'b0;
    end
  end

  // Read data: direct status or window data, one cycle later
  always_comb
  begin
    io_rdata_nxt = 8'h00;
    if (io_dir_hit)
    begin
      case (io_ofs)
        hswb_pkg::OFS_BOARD_CTRL:
          io_rdata_nxt = {config_switch_bank[7:6], 3'b000,
                          dev_irq, board_ctrl_r[1:0]};
        default: io_rdata_nxt = 8'h00;
      endcase
    end
    else if (io_win_hit)
      io_rdata_nxt = io_rdata;
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      host_io_rdata <= 8'h00;
    else if (host_io_rd)
      host_io_rdata <= io_rdata_nxt;
  end

  // Interrupt request level towards the ISA IRQ line
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      host_irq <= 1'b0;
    else
      host_irq <= dev_irq;
  end

  // ---------------------------------------------------------------
  // Local processor clock and halt
  // ---------------------------------------------------------------
  logic [3:0] div_r;

  // Integer divider gives about 16.7 MHz; exact 16 needs a PLL
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      div_r     <= 4'h0;
      lproc_clk <= 1'b0;
    end
    else if (div_r == 4'(hswb_pkg::LPROC_DIV - 1))
    begin
      div_r     <= 4'h0;
      lproc_clk <= ~lproc_clk;
    end
    else
      div_r <= div_r + 4'h1;
  end

  assign lproc_halt = board_ctrl_r[hswb_pkg::BC_HALT_BIT];

endmodule : hswb_bridge

// >>> verification/hswb_bridge_monitor.sv
// Checker: window decode, arbitration and timing of the bridge
`timescale 1ns/1ps

module hswb_bridge_monitor (
  input wire logic                  ref_clk,
  input wire logic                  srst,
  input wire logic [7:0]            config_switch_bank,
  input wire logic                  host_mem_req,
  input wire logic [23:0]           host_mem_addr,
  input wire logic [1:0]            host_mem_be,
  input wire logic                  host_mem_claim,
  input wire logic                  host_mem_ack,
  input wire logic [9:0]            host_io_addr,
  input wire logic [7:0]            host_io_wdata,
  input wire logic                  host_io_wr,
  input wire logic                  dev_irq,
  input wire logic                  host_irq,
  input wire logic                  lproc_mgnt,
  input wire logic                  lproc_halt,
  input wire logic                  lproc_clk,
  input wire logic                  hdlc_mgnt,
  input wire hswb_pkg::hswb_mreq_t  mem_bus,
  input wire logic                  mem_dram_sel,
  input wire logic                  mem_flash_sel,
  input wire logic [1:0]            mem_lane_en
);
  // ---------------------------------------------------------------
  // Shadow of the window registers
  // ---------------------------------------------------------------
  logic [15:0] base_r;
  logic [15:0] mask_r;
  logic [15:0] tgt_r;
  logic        halt_r;
  logic        hit;
  logic [25:0] exp_addr;

  // Direct register write decode at the switch base
  assign hit = host_io_wr && host_io_addr[9:4] == config_switch_bank[5:0];
  // Wraps inside 26 bits, as the on-board space does
  assign exp_addr = {2'b00, host_mem_addr} - {2'b00, base_r, 8'h00}
                    + {tgt_r, 10'h000};

  // Same reset values as the bridge, so no warm-up is needed
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      base_r <= hswb_pkg::RST_HOST_BASE;
      mask_r <= hswb_pkg::RST_SIZE_MASK;
      tgt_r  <= hswb_pkg::RST_TGT_OFFSET;
      halt_r <= hswb_pkg::RST_BOARD_CTRL[0];
    end
    else if (hit)
    begin
      case (host_io_addr[3:0])
        4'h0: base_r[7:0] <= host_io_wdata;
        4'h1: base_r[15:8] <= host_io_wdata;
        4'h2: mask_r[7:0] <= host_io_wdata;
        4'h3: mask_r[15:8] <= host_io_wdata;
        4'h4: tgt_r[7:0] <= host_io_wdata;
        4'h5: tgt_r[15:8] <= host_io_wdata;
        4'hf: halt_r <= host_io_wdata[0];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  sequence s_ack;
    host_mem_ack && mem_bus.valid;
  endsequence
  sequence s_high3;
    lproc_clk [*3] ##1 !lproc_clk;
  endsequence

  property p_claim;
    host_mem_claim == (host_mem_req &&
      ((host_mem_addr[23:8] ^ base_r) & mask_r) == 16'h0000);
  endproperty
  property p_ack;
    host_mem_claim |=> s_ack ##0 mem_bus.addr == $past(exp_addr);
  endproperty
  property p_ack_cause;
    host_mem_ack |-> $past(host_mem_claim);
  endproperty
  property p_lane;
    host_mem_claim |=> mem_lane_en == $past(host_mem_be);
  endproperty
  property p_prio;
    host_mem_claim |=> !hdlc_mgnt && !lproc_mgnt;
  endproperty
  property p_sel;
    mem_bus.valid |->
      mem_flash_sel == (mem_bus.addr >= hswb_pkg::FLASH_BASE) &&
      mem_dram_sel == (mem_bus.addr < hswb_pkg::DRAM_LIMIT);
  endproperty
  property p_halt;
    lproc_halt == halt_r;
  endproperty
  property p_halt_block;
    lproc_halt && $past(lproc_halt) |-> !lproc_mgnt;
  endproperty
  property p_irq;
    1'b1 |=> host_irq == $past(dev_irq);
  endproperty
  property p_lclk;
    $rose(lproc_clk) |-> s_high3;
  endproperty

  a_claim: assert property (p_claim) else $error("claim wrong");
  a_ack: assert property (p_ack) else $error("target wrong");
  a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
  a_lane: assert property (p_lane) else $error("lanes wrong");
  a_prio: assert property (p_prio) else $error("grant clash");
  a_sel: assert property (p_sel) else $error("select wrong");
  a_halt: assert property (p_halt) else $error("halt wrong");
  a_halt_block: assert property (p_halt_block) else $error("grant");
  a_irq: assert property (p_irq) else $error("irq wrong");
  a_lclk: assert property (p_lclk) else $error("lclk wrong");
endmodule : hswb_bridge_monitor

bind hswb_bridge hswb_bridge_monitor i_hswb_bridge_monitor (.ref_clk, .srst,
  .config_switch_bank, .host_mem_req, .host_mem_addr, .host_mem_be,
  .host_mem_claim, .host_mem_ack, .host_io_addr, .host_io_wdata,
  .host_io_wr, .dev_irq, .host_irq, .lproc_mgnt, .lproc_halt, .lproc_clk,
  .hdlc_mgnt, .mem_bus, .mem_dram_sel, .mem_flash_sel, .mem_lane_en);

// >>> verification/hswb_local_mem.sv
// Partner: local memory and I/O devices answering the bridge's buses
`timescale 1ns/1ps

module hswb_local_mem (
  input  wire logic                  ref_clk,
  input  wire hswb_pkg::hswb_mreq_t  mem_bus,
  input  wire hswb_pkg::hswb_ioreq_t io_bus,
  output logic [15:0]                mem_rdata = 16'h0000,
  output logic [7:0]                 io_rdata = 8'h00
);
  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  // Any word reads alone; idle cycles invert so stale data never match
  always_ff @(posedge ref_clk)
  begin
    if (mem_bus.valid)
      mem_rdata <= mem_bus.addr[16:1] ^ 16'h5a5a;
    else
      mem_rdata <= ~mem_rdata;
    if (io_bus.valid)
      io_rdata <= io_bus.addr[7:0];
    else
      io_rdata <= ~io_rdata;
  end
endmodule : hswb_local_mem

// >>> verification/tb.sv
// Testbench: host memory, host I/O and local masters of the bridge
`timescale 1ns/1ps

module tb;
  logic ref_clk, srst, host_mem_req, host_mem_write, host_mem_claim;
  logic host_mem_ack, host_io_wr, host_io_rd, host_io_claim, dev_irq;
  logic host_irq, lproc_mgnt, lproc_iognt, lproc_halt, lproc_clk;
  logic hdlc_mgnt, mem_dram_sel, mem_flash_sel;
  logic [7:0] config_switch_bank, host_io_wdata, host_io_rdata, io_rdata;
  logic [23:0] host_mem_addr;
  logic [15:0] host_mem_wdata, host_mem_rdata, mem_rdata;
  logic [1:0] host_mem_be, mem_lane_en;
  logic [3:0] mem_flash_sector;
  logic [9:0] host_io_addr;
  logic [9:0] iob;
  hswb_pkg::hswb_mreq_t lproc_mreq, hdlc_mreq, mem_bus;
  hswb_pkg::hswb_ioreq_t lproc_ioreq, io_bus;
  int miscompares, comparisons, cycles;

  hswb_bridge i_hswb_bridge (.ref_clk, .srst, .config_switch_bank,
    .host_mem_req, .host_mem_write, .host_mem_addr, .host_mem_wdata,
    .host_mem_be, .host_mem_claim, .host_mem_ack, .host_mem_rdata,
    .host_io_addr, .host_io_wdata, .host_io_wr, .host_io_rd, .host_io_rdata,
    .host_io_claim, .dev_irq, .host_irq, .lproc_mreq, .lproc_ioreq,
    .lproc_mgnt, .lproc_iognt, .lproc_halt, .lproc_clk, .hdlc_mreq,
    .hdlc_mgnt, .mem_bus, .mem_dram_sel, .mem_flash_sel, .mem_flash_sector,
    .mem_lane_en, .mem_rdata, .io_bus, .io_rdata);
  hswb_local_mem i_hswb_local_mem (.ref_clk, .mem_bus, .io_bus, .mem_rdata,
    .io_rdata);

  // ---------------------------------------------------------------
  // Bus tasks and checking
  // ---------------------------------------------------------------
  task automatic cmp(string what, logic [25:0] exp, logic [25:0] got);
    comparisons++;
    if (exp !== got)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  // One-cycle write strobe; the trailing edge keeps strobes apart
  task automatic io_wr(logic [3:0] off, logic [7:0] d);
    @(posedge ref_clk);
    host_io_addr <= iob + 10'(off);
    host_io_wdata <= d;
    host_io_wr <= 1'b1;
    @(posedge ref_clk);
    host_io_wr <= 1'b0;
  endtask : io_wr

  task automatic io_rd(logic [3:0] off, logic [7:0] e);
    @(posedge ref_clk);
    host_io_addr <= iob + 10'(off);
    host_io_rd <= 1'b1;
    @(posedge ref_clk);
    host_io_rd <= 1'b0;
    #1 cmp("io rdata", 26'(e), 26'(host_io_rdata));
    cmp("io claim", 26'h1, 26'(host_io_claim));
  endtask : io_rd

  task automatic mem(logic [23:0] a, logic [1:0] be, logic c,
                     logic [25:0] ea);
    @(posedge ref_clk);
    host_mem_req <= 1'b1;
    host_mem_addr <= a;
    host_mem_be <= be;
    #1 cmp("claim", 26'(c), 26'(host_mem_claim));
    @(posedge ref_clk);
    host_mem_req <= 1'b0;
    #1 cmp("ack", 26'(c), 26'(host_mem_ack));
    if (c)
    begin
      cmp("addr", ea, mem_bus.addr);
      cmp("lanes", 26'(be), 26'(mem_lane_en));
      cmp("flash", 26'(ea >= hswb_pkg::FLASH_BASE), 26'(mem_flash_sel));
    end
  endtask : mem

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_window;
    io_wr(4'h0, 8'h00);
    io_wr(4'h1, 8'h0d);
    io_wr(4'h2, 8'h80);
    io_wr(4'h3, 8'hff);
    io_wr(4'h4, 8'h02);
    io_wr(4'h5, 8'h00);
    mem(24'h0d000e, 2'b11, 1'b1, 26'h000080e);
    mem(24'h0d7fff, 2'b10, 1'b1, 26'h00087ff);
    mem(24'h0d8000, 2'b01, 1'b0, 26'h0);
    mem(24'h0cffff, 2'b01, 1'b0, 26'h0);
    $display("window test done");
  endtask : t_window

  // Smallest practical window moved onto the top of flash
  task automatic t_slide;
    io_wr(4'h2, 8'hfc);
    io_wr(4'h4, 8'hfc);
    io_wr(4'h5, 8'hff);
    mem(24'h0d000e, 2'b01, 1'b1, 26'h3fff00e);
    cmp("sector", 26'ha, 26'(mem_flash_sector));
    mem(24'h0d03ff, 2'b11, 1'b1, 26'h3fff3ff);
    mem(24'h0d0400, 2'b11, 1'b0, 26'h0);
    $display("slide test done");
  endtask : t_slide

  task automatic t_io;
    io_rd(4'hf, 8'h81);
    io_rd(4'hc, 8'h00);
    iob = 10'h240;
    io_wr(4'h1, 8'h55);
    #1 cmp("io claim", 26'h0, 26'(host_io_claim));
    iob = 10'h220;
    mem(24'h0d000e, 2'b11, 1'b1, 26'h3fff00e);
    io_wr(4'hf, 8'h00);
    #1 cmp("halt", 26'h0, 26'(lproc_halt));
    @(posedge ref_clk);
    dev_irq <= 1'b1;
    @(posedge ref_clk);
    @(posedge ref_clk);
    #1 cmp("irq", 26'h1, 26'(host_irq));
    io_rd(4'hf, 8'h84);
    @(posedge ref_clk);
    dev_irq <= 1'b0;
    $display("io test done");
  endtask : t_io

  // Host beats both local masters, then HDLC beats the processor
  task automatic t_arb;
    int n;
    @(posedge ref_clk);
    hdlc_mreq <= '{1'b1, 1'b0, 26'h0001000, 16'h0000, 2'b11};
    lproc_mreq <= '{1'b1, 1'b0, 26'h0002000, 16'h0000, 2'b11};
    lproc_ioreq <= '{1'b1, 1'b0, 10'h011, 8'h00};
    host_mem_req <= 1'b1;
    host_mem_addr <= 24'h0d0010;
    @(posedge ref_clk);
    host_mem_req <= 1'b0;
    #1 cmp("ack", 26'h1, 26'(host_mem_ack));
    fork
      io_wr(4'h8, 8'h01);
      for (n = 0; n < 6 && hdlc_mgnt !== 1'b1; n++)
        @(negedge ref_clk);
    join
    cmp("hdlc gnt", 26'h1, 26'(hdlc_mgnt));
    cmp("lproc gnt", 26'h0, 26'(lproc_mgnt));
    cmp("io gnt", 26'h1, 26'(lproc_iognt));
    @(posedge ref_clk);
    hdlc_mreq.valid <= 1'b0;
    for (n = 0; n < 6 && lproc_mgnt !== 1'b1; n++)
      @(negedge ref_clk);
    cmp("lproc gnt", 26'h1, 26'(lproc_mgnt));
    // Halt again with requests still up: both grants must drop
    io_wr(4'hf, 8'h01);
    @(posedge ref_clk);
    #1 cmp("lproc gnt", 26'h0, 26'(lproc_mgnt));
    cmp("io gnt", 26'h0, 26'(lproc_iognt));
    cmp("halt", 26'h1, 26'(lproc_halt));
    @(posedge ref_clk);
    lproc_mreq.valid <= 1'b0;
    lproc_ioreq.valid <= 1'b0;
    $display("arbitration test done");
  endtask : t_arb

  task automatic final_report;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  // ---------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ---------------------------------------------------------------
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Whole run needs well under a thousand cycles
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      miscompares++;
      final_report();
    end
  end

  initial
  begin
    {srst, host_mem_req, host_mem_write, host_io_wr, host_io_rd} = 5'h10;
    {dev_irq, host_mem_addr, host_mem_wdata, host_mem_be} = '0;
    {host_io_addr, host_io_wdata} = '0;
    {lproc_mreq, hdlc_mreq, lproc_ioreq} = '0;
    config_switch_bank = 8'ha2;
    iob = 10'h220;
    repeat (12) @(posedge ref_clk);
    srst <= 1'b0;
    t_window();
    t_slide();
    t_io();
    t_arb();
    final_report();
  end
endmodule : tb
